// *** rtl/pll_clock_and_reset_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pll_seq_map.svh"

module pll_clock_and_reset_sequencer
    import pll_seq_pkg::*;
#(
    parameter int LOCK_CYC = `PLL_LOCK_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic pll_disable_strap,
    input wire logic boot_location_strap,
    input wire logic [`BOOT_PIN_W-1:0] boot_mode_pins,
    input wire logic wd_reset_req,
    output logic core_rst_n,
    output logic ext_bus_valid,
    output logic clock_output_pin,
    output logic [4:0] sys_clk_edges,
    output clk_mode_t clock_mode,
    output logic boot_done,
    output logic boot_to_loader,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam logic [17:0] LOCK_LAST = 18'(LOCK_CYC - 1);
    localparam logic [11:0] BOOT_EDGES = 12'(`BOOT_SYS_CYC * `EDGES_PER_SYS);

    seq_state_t st_r;
    seq_state_t st_nxt;
    clk_mode_t mode;
    logic req;
    logic wr_go;
    logic [31:0] stat_word;
    logic [1:0] div_sel;

    localparam int STRAP_N = 2 + `BOOT_PIN_W;
    localparam int LAST_STRAP = STRAP_N - 1;

    logic rst_agree;
    logic [STRAP_N-1:0] strap_s2;
    logic [STRAP_N-1:0] strap_s3;
    logic [STRAP_N-1:0] strap_agree;
    logic straps_settled;
    logic boot_pins_settled;
    logic sel_ctrl;
    logic sel_xcfg;
    logic sel_stat;
    logic rd_take;
    logic wr_ctrl;
    logic wr_xcfg;
    logic [`MULT_W-1:0] mult_wdata;
    logic mult_wr_nonzero;
    logic lock_expired;
    logic bus_last;
    logic [11:0] boot_cnt_sum;
    logic boot_reached;
    logic [4:0] rate_sel;
    logic [31:0] rd_word;
    logic [9:0] wd_cnt_upd;
    logic [17:0] lock_cnt_upd;
    logic [5:0] bus_cnt_upd;
    logic [11:0] boot_cnt_upd;
    logic [7:0] acc_upd;
    logic clk_out_upd;

    always_comb begin
        if (st_r.pll_dis) begin
            mode = M_DIS;
        end else if (st_r.mult_act != '0) begin
            mode = M_PLL;
        end else begin
            mode = M_BYP;
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[1:0] = mode;
        stat_word[2] = st_r.locking;
        stat_word[3] = st_r.mp_mode;
        stat_word[5:4] = st_r.boot_st;
        stat_word[9:6] = st_r.boot_mode;
        stat_word[10] = st_r.to_loader;
        stat_word[11] = st_r.bus_valid;
        stat_word[15:12] = st_r.mult_act;
    end

    assign req = avs_read | avs_write;
    assign wr_go = avs_write & st_r.ack;
    assign div_sel = {1'b0, st_r.xcfg[0]} + {1'b0, st_r.xcfg[1]};

    assign rst_agree = st_r.s_rst[1] == st_r.s_rst[2];
    assign strap_s2 = {st_r.s_pll[1], st_r.s_bl[1], st_r.s_bm[1]};
    assign strap_s3 = {st_r.s_pll[2], st_r.s_bl[2], st_r.s_bm[2]};

    // A strap bit counts only once stages two and three agree
    generate
        for (genvar i = 0; i < STRAP_N; i++) begin : g_strap
            assign strap_agree[i] = strap_s2[i] == strap_s3[i];
        end
    endgenerate
    assign straps_settled = &strap_agree[LAST_STRAP:LAST_STRAP-1];
    assign boot_pins_settled = &strap_agree[`BOOT_PIN_W-1:0];

    assign sel_ctrl = avs_address == `CTRL_OFS;
    assign sel_xcfg = avs_address == `XCFG_OFS;
    assign sel_stat = avs_address == `STAT_OFS;
    assign rd_take = req & ~st_r.ack;
    assign wr_ctrl = wr_go & sel_ctrl;
    assign wr_xcfg = wr_go & sel_xcfg;
    assign mult_wdata = avs_writedata[`MULT_W-1:0];
    assign mult_wr_nonzero = mult_wdata != '0;
    assign lock_expired = st_r.locking & (st_r.lock_cnt == '0);
    assign bus_last = st_r.bus_cnt == `BUS_VALID_CYC - 6'd1;
    assign boot_cnt_sum = st_r.boot_cnt + 12'(st_r.rate);
    assign boot_reached = boot_cnt_sum >= BOOT_EDGES;

    // One boot-mode code goes to destination memory, every other to the loader
    function automatic logic pick_loader(input logic [`BOOT_PIN_W-1:0] code);
        logic hit;
        hit = code == `BOOT_LOADER_CODE;
        return !hit;
    endfunction

    // Read data mux; unmapped offsets read as zero
    always_comb begin
        rd_word = '0;
        if (sel_ctrl) begin
            rd_word[`MULT_W-1:0] = st_r.mult;
        end else if (sel_xcfg) begin
            rd_word[1:0] = st_r.xcfg;
        end else if (sel_stat) begin
            rd_word = stat_word;
        end
    end

    // System-clock edges per input cycle for the mode now in force
    always_comb begin
        unique case (mode)
            M_DIS: rate_sel = `RATE_DIS;
            M_BYP: rate_sel = `RATE_BYP;
            M_PLL: rate_sel = 5'(st_r.mult_act);
            default: rate_sel = `RATE_BYP;
        endcase
    end

    // Watchdog pulse length; a request while a pulse runs is ignored
    always_comb begin
        wd_cnt_upd = st_r.wd_cnt;
        if (st_r.wd_cnt != '0) begin
            wd_cnt_upd = st_r.wd_cnt - 10'd1;
        end else if (wd_reset_req) begin
            wd_cnt_upd = `WD_PULSE_CYC;
        end
    end

    // Lock interval: reloaded by every non-zero multiplier write while the PLL is not disabled
    always_comb begin
        lock_cnt_upd = st_r.lock_cnt;
        if (wr_ctrl && mult_wr_nonzero) begin
            lock_cnt_upd = LOCK_LAST;
        end else if (st_r.locking && !lock_expired) begin
            lock_cnt_upd = st_r.lock_cnt - 18'd1;
        end
    end

    always_comb begin
        bus_cnt_upd = st_r.bus_cnt;
        if (!st_r.rst_in) begin
            bus_cnt_upd = '0;
        end else if (!st_r.bus_valid) begin
            bus_cnt_upd = st_r.bus_cnt + 6'd1;
        end
    end

    always_comb begin
        boot_cnt_upd = st_r.boot_cnt;
        if (!st_r.rst_in) begin
            boot_cnt_upd = '0;
        end else if (st_r.boot_st == B_RUN) begin
            boot_cnt_upd = boot_cnt_sum;
        end
    end

    assign acc_upd = st_r.edge_acc + 8'(st_r.rate);
    // Clock output tap: each set divider bit halves the output once more
    always_comb begin
        unique case (div_sel)
            2'h0: clk_out_upd = st_r.edge_acc[0];
            2'h1: clk_out_upd = st_r.edge_acc[1];
            2'h2: clk_out_upd = st_r.edge_acc[2];
            default: clk_out_upd = st_r.edge_acc[0];
        endcase
    end

    always_comb begin
        st_nxt = st_r;

        // Pin inputs: three flops, a change counts once stages two and three agree
        st_nxt.s_rst = {st_r.s_rst[1:0], reset_pin_in};
        st_nxt.s_pll = {st_r.s_pll[1:0], pll_disable_strap};
        st_nxt.s_bl = {st_r.s_bl[1:0], boot_location_strap};
        st_nxt.s_bm = {st_r.s_bm[1:0], boot_mode_pins};
        if (rst_agree) begin
            st_nxt.rst_in = st_r.s_rst[2];
        end

        // Watchdog pulse on the open-drain reset pin
        st_nxt.wd_cnt = wd_cnt_upd;

        // Register bus: one wait cycle, answer at the second edge
        st_nxt.ack = rd_take;
        if (rd_take) begin
            st_nxt.rdata = rd_word;
        end
        if (wr_xcfg) begin
            st_nxt.xcfg = avs_writedata[1:0];
        end

        // PLL multiplier and lock
        if (st_r.pll_dis) begin
            st_nxt.mult_act = '0;
            st_nxt.locking = 1'b0;
        end else if (wr_ctrl) begin
            st_nxt.mult = mult_wdata;
            if (mult_wr_nonzero) begin
                st_nxt.locking = 1'b1;
                st_nxt.lock_cnt = lock_cnt_upd;
            end else begin
                st_nxt.locking = 1'b0;
                st_nxt.mult_act = '0;
            end
        end else if (st_r.locking) begin
            if (lock_expired) begin
                st_nxt.locking = 1'b0;
                st_nxt.mult_act = st_r.mult;
            end else begin
                st_nxt.lock_cnt = lock_cnt_upd;
            end
        end

        // System clock rate in edges per input cycle
        st_nxt.rate = rate_sel;
        st_nxt.edge_acc = acc_upd;
        st_nxt.clk_out = clk_out_upd;

        // Reset sequencing
        if (!st_r.rst_in) begin
            if (straps_settled) begin
                st_nxt.pll_dis = ~st_r.s_pll[2];
                st_nxt.mp_mode = st_r.s_bl[2];
            end
            st_nxt.bus_cnt = bus_cnt_upd;
            st_nxt.bus_valid = 1'b0;
            st_nxt.boot_st = B_HOLD;
            st_nxt.boot_cnt = boot_cnt_upd;
        end else begin
            if (!st_r.bus_valid) begin
                if (bus_last) begin
                    st_nxt.bus_valid = 1'b1;
                end
                st_nxt.bus_cnt = bus_cnt_upd;
            end
            unique case (st_r.boot_st)
                B_HOLD: begin
                    st_nxt.boot_st = st_r.mp_mode ? B_DONE : B_RUN;
                    st_nxt.to_loader = 1'b0;
                end
                B_RUN: begin
                    // Counts the live rate, so a debugger re-run follows the PLL setting
                    if (boot_reached && boot_pins_settled) begin
                        st_nxt.boot_mode = st_r.s_bm[2];
                        st_nxt.to_loader = pick_loader(st_r.s_bm[2]);
                        st_nxt.boot_st = B_DONE;
                    end
                    st_nxt.boot_cnt = boot_cnt_upd;
                end
                B_DONE: begin
                    st_nxt.boot_st = B_DONE;
                end
                default: st_nxt.boot_st = B_HOLD;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.xcfg <= `XCFG_RST;
            st_r.rate <= `RATE_BYP;
            st_r.boot_st <= B_HOLD;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = st_r.wd_cnt != '0;
    assign core_rst_n = st_r.rst_in;
    assign ext_bus_valid = st_r.bus_valid;
    assign clock_output_pin = st_r.clk_out;
    assign sys_clk_edges = st_r.rate;
    assign clock_mode = mode;
    assign boot_done = st_r.boot_st == B_DONE;
    assign boot_to_loader = st_r.to_loader;
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = req & ~st_r.ack;

endmodule
`default_nettype wire

// *** rtl/pll_seq_map.svh ***
`ifndef PLL_SEQ_MAP_SVH
`define PLL_SEQ_MAP_SVH

// Register byte offsets
`define CTRL_OFS 4'h0
`define XCFG_OFS 4'h4
`define STAT_OFS 4'h8

// Field layout and reset values
`define MULT_W 4
`define BOOT_PIN_W 4
`define XCFG_RST 2'h3
`define BOOT_LOADER_CODE 4'hF

// Timing in input-clock cycles, except BOOT_SYS_CYC in system-clock cycles and EDGES_PER_SYS in edges per system-clock cycle
`define WD_PULSE_CYC 10'd512
`define BUS_VALID_CYC 6'd32
`define BOOT_SYS_CYC 1260
`define EDGES_PER_SYS 2
`define PLL_LOCK_CYC 131072

// Rates, in system-clock edges per input-clock cycle
`define RATE_DIS 5'd2
`define RATE_BYP 5'd1

`endif

// *** rtl/pll_seq_pkg.sv ***
package pll_seq_pkg;
    `include "pll_seq_map.svh"

    typedef enum logic [1:0] {
        M_DIS = 2'b00,
        M_BYP = 2'b01,
        M_PLL = 2'b10
    } clk_mode_t;

    typedef enum logic [1:0] {
        B_HOLD = 2'b00,
        B_RUN = 2'b01,
        B_DONE = 2'b10
    } boot_st_t;

    typedef struct packed {
        logic [2:0] s_rst;
        logic [2:0] s_pll;
        logic [2:0] s_bl;
        logic [2:0][`BOOT_PIN_W-1:0] s_bm;
        logic rst_in;
        logic pll_dis;
        logic mp_mode;
        logic [9:0] wd_cnt;
        logic [5:0] bus_cnt;
        logic bus_valid;
        logic [`MULT_W-1:0] mult;
        logic [`MULT_W-1:0] mult_act;
        logic [17:0] lock_cnt;
        logic locking;
        logic [1:0] xcfg;
        logic [4:0] rate;
        logic [7:0] edge_acc;
        logic clk_out;
        boot_st_t boot_st;
        logic [11:0] boot_cnt;
        logic [`BOOT_PIN_W-1:0] boot_mode;
        logic to_loader;
        logic ack;
        logic [31:0] rdata;
    } seq_state_t;
endpackage

// *** test/board_reset_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module board_reset_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic warm_go,
    input wire logic [5:0] straps_v,
    output logic reset_pin_in,
    output logic pll_disable_strap,
    output logic boot_location_strap,
    output logic [3:0] boot_mode_pins
);
    logic [4:0] low_cnt = 5'h0;
    logic [5:0] held = 6'h0;
    // Pull-up against the button and the device's open drain
    assign reset_pin_in = (low_cnt == 5'h0) && !(reset_pin_oe && !reset_pin_out);
    assign {pll_disable_strap, boot_location_strap, boot_mode_pins} = held;
    always @(posedge ref_clk) begin
        if (warm_go) begin
            low_cnt <= 5'h14;
        end else if (low_cnt != 5'h0) begin
            low_cnt <= low_cnt - 5'h1;
        end
        // Straps move only while nrst or the pin is low, then hold
        if (!nrst || !reset_pin_in) begin
            held <= straps_v;
        end
    end
endmodule
`default_nettype wire

// *** test/pll_seq_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module pll_seq_asserts
    import pll_seq_pkg::*;
#(parameter int LOCK_CYC = 16) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic wd_reset_req,
    input wire logic core_rst_n,
    input wire logic ext_bus_valid,
    input wire logic boot_done,
    input wire logic [4:0] sys_clk_edges,
    input wire clk_mode_t clock_mode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [10:0] oe_len;
    // Length of the running pull-down
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oe_len <= 11'h0;
        end else begin
            oe_len <= reset_pin_oe ? oe_len + 11'h1 : 11'h0;
        end
    end
    chk_pin_low: assert property (reset_pin_out == 1'b0)
        else $error("reset pin driven high");
    chk_wd_start: assert property (wd_reset_req && !reset_pin_oe |=> reset_pin_oe)
        else $error("watchdog pulse not started");
    chk_wd_width: assert property ($fell(reset_pin_oe) |-> oe_len == 11'd512)
        else $error("watchdog pulse length wrong");
    chk_bus_delay: assert property ($rose(core_rst_n) |-> ##[31:32] $rose(ext_bus_valid))
        else $error("bus valid delay wrong");
    chk_rst_quiet: assert property (!core_rst_n |=> !ext_bus_valid && !boot_done)
        else $error("outputs active in reset");
    chk_dis_rate: assert property ($past(clock_mode) == M_DIS |-> sys_clk_edges == 5'h2)
        else $error("disabled rate wrong");
    chk_byp_rate: assert property ($past(clock_mode) == M_BYP |-> sys_clk_edges == 5'h1)
        else $error("bypass rate wrong");
    chk_boot_hold: assert property (boot_done && core_rst_n |=> boot_done || !core_rst_n)
        else $error("boot done dropped");
endmodule
bind pll_clock_and_reset_sequencer pll_seq_asserts #(.LOCK_CYC(LOCK_CYC)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .wd_reset_req(wd_reset_req), .core_rst_n(core_rst_n),
    .ext_bus_valid(ext_bus_valid), .boot_done(boot_done), .sys_clk_edges(sys_clk_edges),
    .clock_mode(clock_mode)
);
`default_nettype wire

// *** test/test_pll_clock_and_reset_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pll_seq_map.svh"
module test_pll_clock_and_reset_sequencer
    import pll_seq_pkg::*;
;
    logic ref_clk, nrst, rp_in, rp_out, rp_oe, pdis, bloc, wd, warm, crst, bvalid, cko;
    logic done, ldr, rd, wr, wreq, prev;
    logic [3:0] pins, addr;
    logic [4:0] edges;
    logic [5:0] straps_v;
    logic [31:0] wdat, rdat, q;
    clk_mode_t mode;
    int miscompares, num_checks, cycles, n;
    pll_clock_and_reset_sequencer #(.LOCK_CYC(16)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .reset_pin_in(rp_in), .reset_pin_out(rp_out),
        .reset_pin_oe(rp_oe), .pll_disable_strap(pdis), .boot_location_strap(bloc),
        .boot_mode_pins(pins), .wd_reset_req(wd), .core_rst_n(crst), .ext_bus_valid(bvalid),
        .clock_output_pin(cko), .sys_clk_edges(edges), .clock_mode(mode), .boot_done(done),
        .boot_to_loader(ldr), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq)
    );
    board_reset_model u_board (
        .ref_clk(ref_clk), .nrst(nrst), .reset_pin_out(rp_out), .reset_pin_oe(rp_oe),
        .warm_go(warm), .straps_v(straps_v), .reset_pin_in(rp_in),
        .pll_disable_strap(pdis), .boot_location_strap(bloc), .boot_mode_pins(pins)
    );
    always #2 ref_clk = ~ref_clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do @(posedge ref_clk); while (wreq);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic boot_run(input int lo, input int hi, input logic ld);
        n = 0;
        while (crst) @(negedge ref_clk);
        while (!crst) @(negedge ref_clk);
        while (!done) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
        if (hi > 8) chk(ldr, ld);
    endtask
    initial begin
        {ref_clk, nrst, wd, warm, rd, wr} = 6'h0;
        addr = 4'h0;
        wdat = 32'h0;
        straps_v = 6'h2F;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        boot_run(2516, 2526, 1'b0);
        chk(mode, M_BYP);
        chk(edges, 5'h1);
        n = 0;
        prev = cko;
        repeat (64) begin
            @(negedge ref_clk);
            n += (cko !== prev);
            prev = cko;
        end
        chk(n, 16);
        bus(1'b0, `XCFG_OFS, 32'h0);
        chk(q, 32'h3);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `CTRL_OFS, 32'h3);
        @(negedge ref_clk);
        chk(edges, 5'h1);
        repeat (24) @(negedge ref_clk);
        chk(mode, M_PLL);
        chk(edges, 5'h3);
        straps_v <= 6'h25;
        @(posedge ref_clk);
        wd <= 1'b1;
        @(posedge ref_clk);
        wd <= 1'b0;
        n = 0;
        while (!rp_oe) @(negedge ref_clk);
        while (rp_oe) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, 512);
        boot_run(836, 846, 1'b1);
        straps_v <= 6'h1F;
        @(posedge ref_clk);
        warm <= 1'b1;
        @(posedge ref_clk);
        warm <= 1'b0;
        boot_run(0, 4, 1'b0);
        chk(mode, M_DIS);
        chk(edges, 5'h2);
        bus(1'b0, `STAT_OFS, 32'h0);
        chk(q[3], 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
